// ### pwmro_regs.vh
// Register map, field positions and reset values of the PWM reload/overrun control block
`ifndef PWMRO_REGS_VH
`define PWMRO_REGS_VH

// ****************************************
// Word indexes (byte address = 4 * index)
// ****************************************
`define PWMRO_IDX_LOAD_OK   4'h0
`define PWMRO_IDX_CFG       4'h1
`define PWMRO_IDX_RFLAG     4'h2
`define PWMRO_IDX_ROIE      4'h3
`define PWMRO_IDX_ROIF      4'h4
`define PWMRO_IDX_CNTA      4'h5
`define PWMRO_IDX_PERIOD    4'h6
`define PWMRO_IDX_DUTY      4'h7
`define PWMRO_IDX_IRQCLR    4'h8

// ****************************************
// Load-ok register fields
// ****************************************
`define PWMRO_LOK_GLOBAL    0
`define PWMRO_LOK_A         1
`define PWMRO_LOK_B         2
`define PWMRO_LOK_C         3

// ****************************************
// Configuration register fields
// ****************************************
`define PWMRO_CFG_MSK_LO    0
`define PWMRO_CFG_MSK_HI    5
`define PWMRO_CFG_SRC_LO    6
`define PWMRO_CFG_SRC_HI    7
`define PWMRO_CFG_INV_LO    8
`define PWMRO_CFG_INV_HI    10
`define PWMRO_CFG_PRS_LO    12
`define PWMRO_CFG_PRS_HI    13
`define PWMRO_CFG_FRQ_LO    16
`define PWMRO_CFG_FRQ_HI    19

// ****************************************
// Status layout: overrun A/B/C, reload flag A
// ****************************************
`define PWMRO_ST_OVR_A      0
`define PWMRO_ST_OVR_B      1
`define PWMRO_ST_OVR_C      2
`define PWMRO_ST_RFLAG_A    3

// ****************************************
// Reload source codes
// ****************************************
`define PWMRO_SRC_NONE      2'h0
`define PWMRO_SRC_A         2'h1
`define PWMRO_SRC_B         2'h2
`define PWMRO_SRC_C         2'h3

// ****************************************
// Reset values
// ****************************************
`define PWMRO_RST_LOAD_OK   4'h0
`define PWMRO_RST_CFG       20'h00000
`define PWMRO_RST_ROIE      4'h0
`define PWMRO_RST_PERIOD    15'h00FF
`define PWMRO_RST_DUTY      15'h0080

`endif

// ### pwmro_top.v
// Reload, overrun and interrupt control of PWM generator A with Avalon-MM registers
//
// Function
// R1 - Overrun flag B or C sets on its reload while its load-ok and global load-ok clear.
// R2 - Overrun flag A checks load-ok A/B/C per source code 01/10/11; 00 never.
// R3 - Overrun flags always readable; writing one clears a flag, zero leaves it.
// R4 - Enable bits 2,1,0 gate overrun interrupts of generators C, B, A.
// R5 - Reload flag A sets at every reload cycle start, regardless of load-ok bits.
// R6 - Reload flag A clears by read-while-set then write one; intervening reload voids it.
// R7 - Clearing reload flag A withdraws its pending interrupt request.
// R8 - Reload happens once every N+1 PWM opportunities, N the 4-bit frequency field.
// R9 - Prescaler codes 00..11 divide the core clock by 1, 2, 4, 8.
// R10 - Current 15-bit counter A value readable; writes to it do nothing.
// R11 - Six-bit channel mask suppresses channel pairs for bipolar commutation.
// R12 - Interrupt asserted while any flag and its enable are set, until cleared.

`include "pwmro_regs.vh"

module pwmro_top #(
  parameter CNT_W = 15
) (
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        RST_N_I,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // Reload events of generators B and C
  input  wire        RELOAD_B_I,
  input  wire        RELOAD_C_I,
  // Outputs to the gate driver and the interrupt controller
  output wire [5:0]  PWM_O,
  output wire        RELOAD_A_O,
  output wire        IRQ_O
);

  // ****************************************
  // State
  // ****************************************
  reg              wait_ff;
  reg [31:0]       rdata_ff;
  reg [3:0]        lok_ff;
  reg [19:0]       cfg_ff;
  reg [3:0]        roie_ff;
  reg [2:0]        ovf_ff;
  reg              rfa_ff;
  reg              rfa_arm_ff;
  reg [2:0]        pre_ff;
  reg [CNT_W-1:0]  cnt_ff;
  reg [3:0]        div_ff;
  reg [CNT_W-1:0]  period_ff;
  reg [CNT_W-1:0]  duty_ff;
  reg [5:0]        pwm_ff;
  reg              rel_a_ff;
  reg              irq_ff;

  reg              nxt_wait;
  reg [31:0]       nxt_rdata;
  reg [3:0]        nxt_lok;
  reg [19:0]       nxt_cfg;
  reg [3:0]        nxt_roie;
  reg [2:0]        nxt_ovf;
  reg              nxt_rfa;
  reg              nxt_rfa_arm;
  reg [2:0]        nxt_pre;
  reg [CNT_W-1:0]  nxt_cnt;
  reg [3:0]        nxt_div;
  reg [CNT_W-1:0]  nxt_period;
  reg [CNT_W-1:0]  nxt_duty;
  wire [5:0]       nxt_pwm;
  reg              nxt_irq;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        bus_req = AVS_READ_I | AVS_WRITE_I;
  wire        take    = bus_req & ~wait_ff;
  wire        wr      = AVS_WRITE_I & take;
  wire        rd      = AVS_READ_I & take;
  wire [31:0] wmask   = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                         {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire [31:0] wd      = AVS_WRITEDATA_I & wmask;

  wire wr_lok    = wr & (AVS_ADDRESS_I == `PWMRO_IDX_LOAD_OK);
  wire wr_cfg    = wr & (AVS_ADDRESS_I == `PWMRO_IDX_CFG);
  wire wr_rflag  = wr & (AVS_ADDRESS_I == `PWMRO_IDX_RFLAG);
  wire wr_roie   = wr & (AVS_ADDRESS_I == `PWMRO_IDX_ROIE);
  wire wr_roif   = wr & (AVS_ADDRESS_I == `PWMRO_IDX_ROIF);
  wire wr_period = wr & (AVS_ADDRESS_I == `PWMRO_IDX_PERIOD);
  wire wr_duty   = wr & (AVS_ADDRESS_I == `PWMRO_IDX_DUTY);
  wire wr_irqclr = wr & (AVS_ADDRESS_I == `PWMRO_IDX_IRQCLR);
  wire rd_rflag  = rd & (AVS_ADDRESS_I == `PWMRO_IDX_RFLAG);

  // ****************************************
  // Configuration fields
  // ****************************************
  wire [5:0] chan_mask  = cfg_ff[`PWMRO_CFG_MSK_HI:`PWMRO_CFG_MSK_LO];
  wire [1:0] src_sel    = cfg_ff[`PWMRO_CFG_SRC_HI:`PWMRO_CFG_SRC_LO];
  wire [2:0] pair_inv   = cfg_ff[`PWMRO_CFG_INV_HI:`PWMRO_CFG_INV_LO];
  wire [1:0] prescale   = cfg_ff[`PWMRO_CFG_PRS_HI:`PWMRO_CFG_PRS_LO];
  wire [3:0] reload_frq = cfg_ff[`PWMRO_CFG_FRQ_HI:`PWMRO_CFG_FRQ_LO];

  // ****************************************
  // Prescaler, counter and reload divider
  // ****************************************
  reg [2:0] pre_term;

  always @* begin
    case (prescale)
      2'h0:    pre_term = 3'h0; // R9
      2'h1:    pre_term = 3'h1; // R9
      2'h2:    pre_term = 3'h3; // R9
      2'h3:    pre_term = 3'h7; // R9
      default: pre_term = 3'h0;
    endcase
  end

  wire pwm_tick = (pre_ff == pre_term);
  wire cnt_wrap = pwm_tick & (cnt_ff >= period_ff);
  // A PWM opportunity is the wrap of counter A
  wire rel_a    = cnt_wrap & (div_ff == reload_frq); // R8

  always @* begin
    nxt_pre = pwm_tick ? 3'h0 : pre_ff + 3'h1; // R9
    nxt_cnt = cnt_ff;
    if (pwm_tick) begin
      nxt_cnt = cnt_wrap ? {CNT_W{1'b0}} : cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    nxt_div = div_ff;
    if (cnt_wrap) begin
      nxt_div = rel_a ? 4'h0 : div_ff + 4'h1; // R8
    end
  end

  // ****************************************
  // Overrun detection
  // ****************************************
  reg ovr_ev_a;
  wire glob_ok  = lok_ff[`PWMRO_LOK_GLOBAL];
  wire ovr_ev_b = RELOAD_B_I & ~(lok_ff[`PWMRO_LOK_B] | glob_ok); // R1
  wire ovr_ev_c = RELOAD_C_I & ~(lok_ff[`PWMRO_LOK_C] | glob_ok); // R1

  always @* begin
    case (src_sel)
      `PWMRO_SRC_A: ovr_ev_a = rel_a & ~(lok_ff[`PWMRO_LOK_A] | glob_ok); // R2
      `PWMRO_SRC_B: ovr_ev_a = rel_a & ~(lok_ff[`PWMRO_LOK_B] | glob_ok); // R2
      `PWMRO_SRC_C: ovr_ev_a = rel_a & ~(lok_ff[`PWMRO_LOK_C] | glob_ok); // R2
      default:      ovr_ev_a = 1'b0; // R2
    endcase
  end

  // ****************************************
  // Flags, load-ok and software registers
  // ****************************************
  wire [2:0] ovr_clr = (wr_roif ? wd[2:0] : 3'h0) | (wr_irqclr ? wd[2:0] : 3'h0);
  wire       rfa_clr = wr_rflag & wd[0] & rfa_arm_ff; // R6

  always @* begin
    // Set wins over a clear in the same cycle
    nxt_ovf = (ovf_ff & ~ovr_clr) | {ovr_ev_c, ovr_ev_b, ovr_ev_a}; // R3
    nxt_rfa = rel_a | (rfa_ff & ~rfa_clr); // R5
    nxt_rfa_arm = rfa_arm_ff;
    if (rel_a) begin
      nxt_rfa_arm = 1'b0; // R6
    end else if (rfa_clr) begin
      nxt_rfa_arm = 1'b0;
    end else if (rd_rflag & rdata_ff[0]) begin
      nxt_rfa_arm = 1'b1; // R6
    end

    // Load-ok of a generator is consumed by its reload; a write in that cycle wins
    nxt_lok = lok_ff;
    if (rel_a) begin
      nxt_lok[`PWMRO_LOK_A] = 1'b0;
    end
    if (RELOAD_B_I) begin
      nxt_lok[`PWMRO_LOK_B] = 1'b0;
    end
    if (RELOAD_C_I) begin
      nxt_lok[`PWMRO_LOK_C] = 1'b0;
    end
    if (wr_lok) begin
      nxt_lok = (nxt_lok & ~wmask[3:0]) | wd[3:0];
    end

    nxt_cfg    = wr_cfg ? ((cfg_ff & ~wmask[19:0]) | wd[19:0]) : cfg_ff;
    nxt_roie   = wr_roie ? ((roie_ff & ~wmask[3:0]) | wd[3:0]) : roie_ff; // R4
    nxt_period = wr_period ? ((period_ff & ~wmask[CNT_W-1:0]) | wd[CNT_W-1:0]) : period_ff;
    nxt_duty   = wr_duty ? ((duty_ff & ~wmask[CNT_W-1:0]) | wd[CNT_W-1:0]) : duty_ff;

    // Taken from next flag values so a clear drops the request at the same edge
    nxt_irq = |({nxt_rfa, nxt_ovf} & roie_ff); // R12 R7 R4
  end

  // ****************************************
  // Read path and wait-state
  // ****************************************
  // One wait cycle per access: data is latched in the cycle before the accepting edge
  reg [31:0] rd_mux;

  always @* begin
    case (AVS_ADDRESS_I)
      `PWMRO_IDX_LOAD_OK: rd_mux = {28'h0000000, lok_ff};
      `PWMRO_IDX_CFG:     rd_mux = {12'h000, cfg_ff};
      `PWMRO_IDX_RFLAG:   rd_mux = {31'h00000000, rfa_ff};
      `PWMRO_IDX_ROIE:    rd_mux = {28'h0000000, roie_ff};
      `PWMRO_IDX_ROIF:    rd_mux = {29'h00000000, ovf_ff}; // R3
      `PWMRO_IDX_CNTA:    rd_mux = {{(32-CNT_W){1'b0}}, cnt_ff}; // R10
      `PWMRO_IDX_PERIOD:  rd_mux = {{(32-CNT_W){1'b0}}, period_ff};
      `PWMRO_IDX_DUTY:    rd_mux = {{(32-CNT_W){1'b0}}, duty_ff};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always @* begin
    nxt_wait  = ~(wait_ff & bus_req);
    nxt_rdata = (wait_ff & AVS_READ_I) ? rd_mux : rdata_ff;
  end

  // ****************************************
  // Channel outputs
  // ****************************************
  // Complementary pairs; each mask bit forces its own switch of a branch off
  wire gen_a = (cnt_ff < duty_ff);

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pair
      wire raw = pair_inv[p] ? ~gen_a : gen_a;
      assign nxt_pwm[2*p]   = ~chan_mask[2*p] & raw; // R11
      assign nxt_pwm[2*p+1] = ~chan_mask[2*p+1] & ~raw; // R11
    end
  endgenerate

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wait_ff    <= 1'b1;
      rdata_ff   <= 32'h00000000;
      lok_ff     <= `PWMRO_RST_LOAD_OK;
      cfg_ff     <= `PWMRO_RST_CFG;
      roie_ff    <= `PWMRO_RST_ROIE;
      ovf_ff     <= 3'h0;
      rfa_ff     <= 1'b0;
      rfa_arm_ff <= 1'b0;
      pre_ff     <= 3'h0;
      cnt_ff     <= {CNT_W{1'b0}};
      div_ff     <= 4'h0;
      period_ff  <= `PWMRO_RST_PERIOD;
      duty_ff    <= `PWMRO_RST_DUTY;
      pwm_ff     <= 6'h00;
      rel_a_ff   <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      wait_ff    <= nxt_wait;
      rdata_ff   <= nxt_rdata;
      lok_ff     <= nxt_lok;
      cfg_ff     <= nxt_cfg;
      roie_ff    <= nxt_roie;
      ovf_ff     <= nxt_ovf;
      rfa_ff     <= nxt_rfa;
      rfa_arm_ff <= nxt_rfa_arm;
      pre_ff     <= nxt_pre;
      cnt_ff     <= nxt_cnt;
      div_ff     <= nxt_div;
      period_ff  <= nxt_period;
      duty_ff    <= nxt_duty;
      pwm_ff     <= nxt_pwm;
      rel_a_ff   <= rel_a;
      irq_ff     <= nxt_irq;
    end
  end

  assign AVS_READDATA_O    = rdata_ff;
  assign AVS_WAITREQUEST_O = wait_ff;
  assign PWM_O             = pwm_ff;
  assign RELOAD_A_O        = rel_a_ff;
  assign IRQ_O             = irq_ff;

endmodule

// ### pwmro_props.sv
// Assertion checker for the PWM reload and overrun control block
module pwmro_props #(
  parameter CNT_W = 15
) (
  // Clock and reset
  input wire        CLK_SYS_I,
  input wire        RST_N_I,
  // Register bus
  input wire [3:0]  AVS_ADDRESS_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire        AVS_WAITREQUEST_O,
  // Events and interrupt
  input wire        RELOAD_B_I,
  input wire        RELOAD_C_I,
  input wire        RELOAD_A_O,
  input wire        IRQ_O
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helpers
  // ****************************************
  wire rd_acc = AVS_READ_I && !AVS_WAITREQUEST_O;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  // ****************************************
  // Assertions
  // ****************************************
  a_wait_answer: assert property ($rose(AVS_READ_I | AVS_WRITE_I) |=> !AVS_WAITREQUEST_O)
    else $error("request not answered after one wait cycle");
  a_wait_once: assert property ((AVS_READ_I | AVS_WRITE_I) && !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("wait request low for more than one cycle");
  a_flags_width: assert property (rd_acc && AVS_ADDRESS_I == 4'h4 |-> AVS_READDATA_O[31:3] == 29'h0)
    else $error("overrun flag read shows bits above flag C");
  a_enable_width: assert property (rd_acc && AVS_ADDRESS_I == 4'h3 |-> AVS_READDATA_O[31:4] == 28'h0)
    else $error("enable read shows unused bits");
  a_count_width: assert property (rd_acc && AVS_ADDRESS_I == 4'h5 |-> (AVS_READDATA_O >> CNT_W) == 32'h0)
    else $error("counter read wider than the counter");
  a_unmapped_zero: assert property (rd_acc && AVS_ADDRESS_I >= 4'h8 |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped or clear register read not zero");
  // An enable write reaches the interrupt one edge after the write is taken
  a_irq_cause: assert property ($rose(IRQ_O) |->
    (($past(AVS_WRITE_I | RELOAD_B_I | RELOAD_C_I) || $past(AVS_WRITE_I, 2))
      or ##[0:2] RELOAD_A_O))
    else $error("interrupt rose without event or enable write");
  a_irq_fall_write: assert property ($fell(IRQ_O) |->
    ($past(AVS_WRITE_I) || $past(AVS_WRITE_I, 2)))
    else $error("interrupt fell without a clearing write");

  // ****************************************
  // Coverage
  // ****************************************
  c_rflag_read: cover property (rd_acc && AVS_ADDRESS_I == 4'h2);
  c_irq_rise: cover property ($rose(IRQ_O));
  c_irq_fall: cover property ($fell(IRQ_O));
endmodule

bind pwmro_top pwmro_props #(.CNT_W(CNT_W)) pwmro_props_i (.CLK_SYS_I, .RST_N_I, .AVS_ADDRESS_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .RELOAD_B_I, .RELOAD_C_I,
  .RELOAD_A_O, .IRQ_O);

// ### pwmro_gate_model.sv
// Behavioural gate driver that records which channels were switched on
module pwmro_gate_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  // Gate commands
  input  wire logic [5:0] pwm_i,
  output logic      [5:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sticky record, so a brief glitch on a masked channel is not missed
  always @(posedge clk_i) begin
    if (clr_i) begin
      seen_o <= 6'h00;
    end else begin
      seen_o <= seen_o | pwm_i;
    end
  end
endmodule

// ### pwmro_tb.sv
// Self-checking testbench of the PWM reload and overrun control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic [3:0]  AVS_ADDRESS_I = 4'h0;
  logic        AVS_READ_I = 1'b0;
  logic        AVS_WRITE_I = 1'b0;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [3:0]  AVS_BYTEENABLE_I = 4'hF;
  logic [3:0]  be = 4'hF;
  logic        RELOAD_B_I = 1'b0;
  logic        RELOAD_C_I = 1'b0;
  logic        gclr = 1'b1;
  wire  [31:0] AVS_READDATA_O;
  wire         AVS_WAITREQUEST_O;
  wire  [5:0]  PWM_O;
  wire         RELOAD_A_O;
  wire         IRQ_O;
  wire  [5:0]  gseen;
  int          failures = 0;
  int          compares = 0;
  logic [3:0]  ri [6] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'h80, 32'h0};
  logic [6:0]  tbl [8] = '{7'h00, 7'h50, 7'h60, 7'h70, 7'h12, 7'h62, 7'h38, 7'h21};
  logic [5:0]  msk [3] = '{6'h03, 6'h0C, 6'h30};

  always #25 CLK_SYS_I = ~CLK_SYS_I;

  pwmro_top pwmro_top_i (.CLK_SYS_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .RELOAD_B_I,
    .RELOAD_C_I, .PWM_O, .RELOAD_A_O, .IRQ_O);
  pwmro_gate_model pwmro_gate_model_i (.clk_i(CLK_SYS_I), .clr_i(gclr), .pwm_i(PWM_O),
    .seen_o(gseen));

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held up to the edge at which wait request is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK_SYS_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_BYTEENABLE_I <= be;
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    do @(posedge CLK_SYS_I); while (AVS_WAITREQUEST_O !== 1'b0);
    q = AVS_READDATA_O;
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    @(negedge CLK_SYS_I);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task wait_rl(output int n);
    n = 0;
    do begin
      @(negedge CLK_SYS_I);
      n++;
    end while (RELOAD_A_O !== 1'b1);
  endtask
  task pulse(input logic [1:0] bc);
    @(posedge CLK_SYS_I);
    {RELOAD_C_I, RELOAD_B_I} <= bc;
    @(posedge CLK_SYS_I);
    {RELOAD_C_I, RELOAD_B_I} <= 2'b00;
    @(negedge CLK_SYS_I);
  endtask
  task test_done;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [31:0] q;
    wr(4'h9, 32'h5A5A5A5A);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ri[i], 32'h0, q);
      chk("reset_value", q, rv[i]);
    end
  endtask
  task t_ovr_bc;
    logic [31:0] q;
    wr(4'h3, 32'h7);
    wr(4'h0, 32'h0);
    pulse(2'b01);
    chk("irq_b", IRQ_O, 32'h1);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("flag_b", q, 32'h2);
    wr(4'h4, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("write_zero", q, 32'h2);
    wr(4'h4, 32'h2);
    chk("irq_b_clr", IRQ_O, 32'h0);
    wr(4'h0, 32'h4);
    pulse(2'b01);
    wr(4'h0, 32'h1);
    pulse(2'b10);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("loaded_no_flag", q, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h3, 32'h3);
    pulse(2'b10);
    chk("irq_c_off", IRQ_O, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("flag_c", q, 32'h4);
    wr(4'h4, 32'h7);
    wr(4'h3, 32'h0);
  endtask
  task t_src;
    logic [31:0] q;
    int n;
    wr(4'h6, 32'h3);
    wr(4'h7, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(4'h1, {12'h000, 4'hF, 8'h00, tbl[i][5:4], 6'h00});
      wr(4'h0, {28'h0, tbl[i][3:0]});
      wait_rl(n);
      wr(4'h4, 32'h7);
      wr(4'h0, {28'h0, tbl[i][3:0]});
      wait_rl(n);
      bus(1'b0, 4'h4, 32'h0, q);
      chk("flag_a", q, {31'h0, tbl[i][6]});
      bus(1'b0, 4'h2, 32'h0, q);
      chk("rflag_set", q, 32'h1);
    end
    wr(4'h0, 32'h0);
  endtask
  task t_rflag;
    logic [31:0] q;
    int n;
    wr(4'h3, 32'h8);
    wait_rl(n);
    chk("irq_rflag", IRQ_O, 32'h1);
    bus(1'b0, 4'h2, 32'h0, q);
    wr(4'h2, 32'h1);
    chk("irq_withdrawn", IRQ_O, 32'h0);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("rflag_clr", q, 32'h0);
    wait_rl(n);
    bus(1'b0, 4'h2, 32'h0, q);
    wait_rl(n);
    wr(4'h2, 32'h1);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("rflag_kept", q, 32'h1);
    wr(4'h3, 32'h0);
  endtask
  task t_rate;
    logic [3:0] f;
    int n;
    for (int k = 0; k < 4; k++) begin
      f = 4'(k * 5);
      wr(4'h1, {12'h000, f, 2'b00, 2'(k), 12'h000});
      wait_rl(n);
      wait_rl(n);
      wait_rl(n);
      chk("interval", 32'(n), 32'((4 * (f + 1)) << k));
    end
  endtask
  task t_mask;
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, {26'h0, msk[i]});
      repeat (8) @(negedge CLK_SYS_I);
      @(posedge CLK_SYS_I);
      gclr <= 1'b1;
      @(posedge CLK_SYS_I);
      gclr <= 1'b0;
      repeat (40) @(negedge CLK_SYS_I);
      chk("gates_on", gseen, {26'h0, ~msk[i]});
    end
    // Duty zero holds the generator low, so only the inverted pairs drive their high side
    wr(4'h7, 32'h0);
    wr(4'h1, 32'h00000500);
    repeat (4) @(negedge CLK_SYS_I);
    chk("pair_invert", PWM_O, 32'h19);
  endtask
  task t_count;
    logic [31:0] q;
    logic [31:0] p;
    be = 4'h2;
    wr(4'h6, 32'h7FFF);
    be = 4'hF;
    bus(1'b0, 4'h6, 32'h0, q);
    chk("period_lane", q, 32'h7F03);
    // Long period, so a write that landed would show as a large count
    wr(4'h5, 32'h5000);
    bus(1'b0, 4'h5, 32'h0, q);
    chk("count_kept", {31'h0, q < 32'h0100}, 32'h1);
    bus(1'b0, 4'h5, 32'h0, p);
    chk("count_runs", {31'h0, p > q}, 32'h1);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    t_reset;
    t_ovr_bc;
    t_src;
    t_rflag;
    t_rate;
    t_mask;
    t_count;
    test_done;
  end
  // Tests need about 4000 cycles
  initial begin
    repeat (40000) @(posedge CLK_SYS_I);
    failures++;
    test_done;
  end
endmodule
